// ---- hw/rcpl_deglitch.sv ----
`timescale 1ns/10ps
module rcpl_deglitch (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);

    // ==========================================================
    // synchroniser and stability filter
    logic sync_1;
    logic sync_2;
    logic [rcpl_pkg::DGL_CNT_W-1:0] count;
    wire differs = sync_2 != level;
    wire settled = count == rcpl_pkg::DGL_CNT_W'(rcpl_pkg::DEGLITCH_CYC - 1);

    // sync_1 feeds only sync_2 so metastability never reaches logic
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
        end else begin
            sync_1 <= pin;
            sync_2 <= sync_1;
        end
    end

    // any bounce restarts the count
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
            level <= 1'b0;
        end else if (!differs) begin
            count <= '0;
        end else if (settled) begin
            count <= '0;
            level <= sync_2;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule

// ---- hw/rcpl_pkg.sv ----
// Contract
// - a rising rail control input enables every rail assigned to its group.
// - a falling rail control input disables every rail assigned to its group.
// - a dual-role input in sleep role is active low: low sleeps, high wakes.
// - sleeping rails are regulated to their own sleep voltage codes.
// - each general output has its own drive type, open-drain or push-pull.
// - a status output shows the joint power-good of its chosen rails.
// - a host-controlled general output follows a bit that software writes.
// - the interrupt pin is open-drain, pulled low while an interrupt pends.
// - every register access, host output bits too, uses the management bus.
package rcpl_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_RAILS = 8;
    localparam int NUM_CTRL = 6;
    localparam int NUM_GOUT = 3;
    localparam int VSEL_W = 4;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_GROUP_ASSIGN = 8'h00;
    localparam logic [7:0] OFS_SLEEP_CFG = 8'h04;
    localparam logic [7:0] OFS_GOUT_CFG = 8'h08;
    localparam logic [7:0] OFS_PG_SELECT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_VSEL_NORM = 8'h1c;
    localparam logic [7:0] OFS_VSEL_SLEEP = 8'h20;

    // ==========================================================
    // field layout
    localparam int GRP_FIELD_W = 3;
    localparam int SLP_MODE_C_BIT = 0;
    localparam int SLP_MODE_F_BIT = 1;
    localparam int SLP_RAILS_C_LSB = 8;
    localparam int SLP_RAILS_F_LSB = 16;
    localparam int GOUT_FIELD_W = 4;
    localparam int GOUT_PP_BIT = 0;
    localparam int GOUT_HOST_SRC_BIT = 1;
    localparam int GOUT_HOST_VAL_BIT = 2;
    localparam int ST_EN_LSB = 0;
    localparam int ST_SLEEP_LSB = 8;
    localparam int ST_PG_LSB = 16;
    localparam int ST_CTRL_LSB = 24;
    localparam int CTRL_IDX_C = 2;
    localparam int CTRL_IDX_F = 5;

    // ==========================================================
    // reset values
    localparam logic [31:0] RST_GROUP_ASSIGN = 32'h0000_0000;
    localparam logic [31:0] RST_SLEEP_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_GOUT_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_PG_SELECT = 32'h0000_0000;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    localparam logic [31:0] RST_VSEL_NORM = 32'h0000_0000;
    localparam logic [31:0] RST_VSEL_SLEEP = 32'h0000_0000;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEGLITCH_NS = 10000;
    // least time, so round up
    localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int DGL_CNT_W = 10;

    // ==========================================================
    // ahb
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

endpackage

// ---- hw/rcpl_top.sv ----
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module rcpl_top (
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // rail control pins
    input wire logic rail_group_ctrl_a,
    input wire logic rail_group_ctrl_b,
    input wire logic rail_group_ctrl_c,
    input wire logic rail_group_ctrl_d,
    input wire logic rail_group_ctrl_e,
    input wire logic rail_group_ctrl_f,
    // regulator side
    input wire logic [7:0] power_good,
    output logic [7:0] rail_enable,
    output logic [7:0] rail_sleep,
    output logic [31:0] rail_vsel,
    // general outputs
    output logic gen_out_a_o,
    output logic gen_out_a_oe,
    output logic gen_out_b_o,
    output logic gen_out_b_oe,
    output logic gen_out_c_o,
    output logic gen_out_c_oe,
    // interrupt
    output logic irq_out_n_o,
    output logic irq_out_n_oe
);

    // ==========================================================
    // functions
    function automatic logic [7:0] group_members(
        input logic [31:0] assign_reg,
        input int grp
    );
        logic [7:0] m;
        m = '0;
        for (int r = 0; r < rcpl_pkg::NUM_RAILS; r++) begin
            m[r] = assign_reg[r*rcpl_pkg::GRP_FIELD_W +: 3]
                   == 3'(grp + 1);
        end
        return m;
    endfunction

    function automatic logic gout_level(
        input logic [31:0] cfg,
        input logic [31:0] sel,
        input logic [7:0] pg,
        input int idx
    );
        logic [3:0] f;
        logic [7:0] s;
        f = cfg[idx*rcpl_pkg::GOUT_FIELD_W +: 4];
        s = sel[idx*8 +: 8];
        if (f[rcpl_pkg::GOUT_HOST_SRC_BIT]) begin
            return f[rcpl_pkg::GOUT_HOST_VAL_BIT];
        end
        return &(pg | ~s);
    endfunction

    // ==========================================================
    // registers
    logic [31:0] group_assign;
    logic [31:0] sleep_cfg;
    logic [31:0] gout_cfg;
    logic [31:0] pg_select;
    logic [7:0] irq_mask;
    logic [7:0] irq_flag;
    logic [31:0] vsel_norm;
    logic [31:0] vsel_sleep;

    // ==========================================================
    // bus address phase capture
    logic dp_write;
    logic [7:0] dp_addr;
    wire addr_valid = hsel && hready && htrans == rcpl_pkg::HTRANS_NONSEQ;
    wire [7:0] a_ofs = {haddr[7:2], 2'h0};
    wire a_in_range = haddr[31:8] == 24'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= rcpl_pkg::HRESP_OKAY;
        end else begin
            dp_write <= addr_valid && hwrite && a_in_range;
            dp_addr <= a_ofs;
            hreadyout <= 1'b1;
            hresp <= rcpl_pkg::HRESP_OKAY;
        end
    end

    // ==========================================================
    // deglitched control inputs
    logic [5:0] ctrl_raw;
    logic [5:0] ctrl_flt;
    logic [5:0] ctrl_prev;
    assign ctrl_raw = {rail_group_ctrl_f, rail_group_ctrl_e,
                       rail_group_ctrl_d, rail_group_ctrl_c,
                       rail_group_ctrl_b, rail_group_ctrl_a};

    genvar gi;
    generate
        for (gi = 0; gi < rcpl_pkg::NUM_CTRL; gi++) begin : g_dgl
            rcpl_deglitch u_dgl (
                .clk(clk),
                .rst(rst),
                .pin(ctrl_raw[gi]),
                .level(ctrl_flt[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_prev <= 6'h00;
        end else begin
            ctrl_prev <= ctrl_flt;
        end
    end

    // ==========================================================
    // sleep role of the dual-role inputs
    wire sleep_mode_c = sleep_cfg[rcpl_pkg::SLP_MODE_C_BIT];
    wire sleep_mode_f = sleep_cfg[rcpl_pkg::SLP_MODE_F_BIT];
    wire sleep_ctrl_n_a = ctrl_flt[rcpl_pkg::CTRL_IDX_C];
    wire sleep_ctrl_n_b = ctrl_flt[rcpl_pkg::CTRL_IDX_F];
    wire [7:0] sleep_rails_c = sleep_cfg[rcpl_pkg::SLP_RAILS_C_LSB +: 8];
    wire [7:0] sleep_rails_f = sleep_cfg[rcpl_pkg::SLP_RAILS_F_LSB +: 8];
    // low means asleep
    wire [7:0] next_rail_sleep =
        ({8{sleep_mode_c && !sleep_ctrl_n_a}} & sleep_rails_c) |
        ({8{sleep_mode_f && !sleep_ctrl_n_b}} & sleep_rails_f);
    // a pin in sleep role never enables rails
    wire [5:0] enable_role = ~(6'(sleep_mode_c) << rcpl_pkg::CTRL_IDX_C |
                               6'(sleep_mode_f) << rcpl_pkg::CTRL_IDX_F);

    // ==========================================================
    // rail enables, edge driven
    wire [5:0] ctrl_rise = ctrl_flt & ~ctrl_prev & enable_role;
    wire [5:0] ctrl_fall = ~ctrl_flt & ctrl_prev & enable_role;
    logic [7:0] next_rail_enable;

    always_comb begin
        next_rail_enable = rail_enable;
        for (int g = 0; g < rcpl_pkg::NUM_CTRL; g++) begin
            if (ctrl_rise[g]) begin
                next_rail_enable = next_rail_enable
                    | group_members(group_assign, g);
            end
            if (ctrl_fall[g]) begin
                next_rail_enable = next_rail_enable
                    & ~group_members(group_assign, g);
            end
        end
    end

    // ==========================================================
    // voltage selection per rail
    logic [31:0] next_rail_vsel;
    always_comb begin
        next_rail_vsel = vsel_norm;
        for (int r = 0; r < rcpl_pkg::NUM_RAILS; r++) begin
            if (next_rail_sleep[r]) begin
                next_rail_vsel[r*rcpl_pkg::VSEL_W +: 4] =
                    vsel_sleep[r*rcpl_pkg::VSEL_W +: 4];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rail_enable <= 8'h00;
            rail_sleep <= 8'h00;
            rail_vsel <= rcpl_pkg::RST_VSEL_NORM;
        end else begin
            rail_enable <= next_rail_enable;
            rail_sleep <= next_rail_sleep;
            rail_vsel <= next_rail_vsel;
        end
    end

    // ==========================================================
    // general outputs
    wire lvl_a = gout_level(gout_cfg, pg_select, power_good, 0);
    wire lvl_b = gout_level(gout_cfg, pg_select, power_good, 1);
    wire lvl_c = gout_level(gout_cfg, pg_select, power_good, 2);
    wire pp_a = gout_cfg[0*rcpl_pkg::GOUT_FIELD_W + rcpl_pkg::GOUT_PP_BIT];
    wire pp_b = gout_cfg[1*rcpl_pkg::GOUT_FIELD_W + rcpl_pkg::GOUT_PP_BIT];
    wire pp_c = gout_cfg[2*rcpl_pkg::GOUT_FIELD_W + rcpl_pkg::GOUT_PP_BIT];

    // open-drain drives only the low level
    always_ff @(posedge clk) begin
        if (rst) begin
            gen_out_a_o <= 1'b0;
            gen_out_a_oe <= 1'b0;
            gen_out_b_o <= 1'b0;
            gen_out_b_oe <= 1'b0;
            gen_out_c_o <= 1'b0;
            gen_out_c_oe <= 1'b0;
        end else begin
            gen_out_a_o <= pp_a & lvl_a;
            gen_out_a_oe <= pp_a | ~lvl_a;
            gen_out_b_o <= pp_b & lvl_b;
            gen_out_b_oe <= pp_b | ~lvl_b;
            gen_out_c_o <= pp_c & lvl_c;
            gen_out_c_oe <= pp_c | ~lvl_c;
        end
    end

    // ==========================================================
    // power-good loss events and interrupt pin
    logic [7:0] pg_prev;
    wire [7:0] pg_lost = pg_prev & ~power_good & rail_enable;
    wire wr_flag = dp_write && dp_addr == rcpl_pkg::OFS_IRQ_FLAG;
    wire [7:0] flag_clr = wr_flag ? hwdata[7:0] : 8'h00;
    // a loss in the clearing cycle survives the clear
    wire [7:0] next_irq_flag = (irq_flag & ~flag_clr) | pg_lost;

    always_ff @(posedge clk) begin
        if (rst) begin
            pg_prev <= 8'h00;
            irq_flag <= 8'h00;
            irq_out_n_o <= 1'b0;
            irq_out_n_oe <= 1'b0;
        end else begin
            pg_prev <= power_good;
            irq_flag <= next_irq_flag;
            irq_out_n_o <= 1'b0;
            irq_out_n_oe <= |(next_irq_flag & irq_mask);
        end
    end

    // ==========================================================
    // register writes
    wire wr_group = dp_write && dp_addr == rcpl_pkg::OFS_GROUP_ASSIGN;
    wire wr_sleep = dp_write && dp_addr == rcpl_pkg::OFS_SLEEP_CFG;
    wire wr_gout = dp_write && dp_addr == rcpl_pkg::OFS_GOUT_CFG;
    wire wr_pgsel = dp_write && dp_addr == rcpl_pkg::OFS_PG_SELECT;
    wire wr_mask = dp_write && dp_addr == rcpl_pkg::OFS_IRQ_MASK;
    wire wr_vnorm = dp_write && dp_addr == rcpl_pkg::OFS_VSEL_NORM;
    wire wr_vsleep = dp_write && dp_addr == rcpl_pkg::OFS_VSEL_SLEEP;

    always_ff @(posedge clk) begin
        if (rst) begin
            group_assign <= rcpl_pkg::RST_GROUP_ASSIGN;
            sleep_cfg <= rcpl_pkg::RST_SLEEP_CFG;
            gout_cfg <= rcpl_pkg::RST_GOUT_CFG;
            pg_select <= rcpl_pkg::RST_PG_SELECT;
            irq_mask <= rcpl_pkg::RST_IRQ_MASK;
            vsel_norm <= rcpl_pkg::RST_VSEL_NORM;
            vsel_sleep <= rcpl_pkg::RST_VSEL_SLEEP;
        end else begin
            if (wr_group) begin
                group_assign <= {8'h00, hwdata[23:0]};
            end
            if (wr_sleep) begin
                sleep_cfg <= {8'h00, hwdata[23:8], 6'h00, hwdata[1:0]};
            end
            if (wr_gout) begin
                gout_cfg <= {20'h00000, hwdata[11:0]};
            end
            if (wr_pgsel) begin
                pg_select <= {8'h00, hwdata[23:0]};
            end
            if (wr_mask) begin
                irq_mask <= hwdata[7:0];
            end
            if (wr_vnorm) begin
                vsel_norm <= hwdata;
            end
            if (wr_vsleep) begin
                vsel_sleep <= hwdata;
            end
        end
    end

    // ==========================================================
    // read data, registered at the address phase
    wire [31:0] status_word = {2'h0, ctrl_flt, power_good,
                               rail_sleep, rail_enable};
    logic [31:0] rd_mux;

    always_comb begin
        unique case (a_ofs)
            rcpl_pkg::OFS_GROUP_ASSIGN: rd_mux = group_assign;
            rcpl_pkg::OFS_SLEEP_CFG: rd_mux = sleep_cfg;
            rcpl_pkg::OFS_GOUT_CFG: rd_mux = gout_cfg;
            rcpl_pkg::OFS_PG_SELECT: rd_mux = pg_select;
            rcpl_pkg::OFS_IRQ_MASK: rd_mux = {24'h000000, irq_mask};
            rcpl_pkg::OFS_IRQ_FLAG: rd_mux = {24'h000000, irq_flag};
            rcpl_pkg::OFS_STATUS: rd_mux = status_word;
            rcpl_pkg::OFS_VSEL_NORM: rd_mux = vsel_norm;
            rcpl_pkg::OFS_VSEL_SLEEP: rd_mux = vsel_sleep;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // status snapshot is one cycle older than the data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_valid && !hwrite) begin
            hrdata <= a_in_range ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

// ---- sim/rcpl_monitor.sv ----
`timescale 1ns/10ps
// ==========
// pin and bus checks
module rcpl_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rail_group_ctrl_a,
    input wire logic rail_group_ctrl_b,
    input wire logic rail_group_ctrl_c,
    input wire logic rail_group_ctrl_d,
    input wire logic rail_group_ctrl_e,
    input wire logic rail_group_ctrl_f,
    input wire logic [7:0] power_good,
    input wire logic [7:0] rail_enable,
    input wire logic [7:0] rail_sleep,
    input wire logic [31:0] rail_vsel,
    input wire logic gen_out_a_o,
    input wire logic gen_out_a_oe,
    input wire logic irq_out_n_o,
    input wire logic irq_out_n_oe
);
    // any pin edge restarts the count, so pin edges must stay far apart
    logic [5:0] pins;
    logic [5:0] pins_q;
    logic [10:0] quiet;
    assign pins = {rail_group_ctrl_f, rail_group_ctrl_e, rail_group_ctrl_d,
                   rail_group_ctrl_c, rail_group_ctrl_b, rail_group_ctrl_a};
    always_ff @(posedge clk) begin
        pins_q <= pins;
        if (rst || pins != pins_q) begin
            quiet <= 11'h000;
        end else if (quiet != 11'h7ff) begin
            quiet <= quiet + 11'h001;
        end
    end

    // ==========
    // assertions
    default clocking dck @(posedge clk); endclocking
    default disable iff (rst);

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    irq_drive_a: assert property (!irq_out_n_o)
        else $error("interrupt pin driven high");
    gout_drive_a: assert property (gen_out_a_o |-> gen_out_a_oe)
        else $error("output high while not driven");
    en_filter_a: assert property ($changed(rail_enable)
        |-> quiet >= 11'h3e7) else $error("enable moved before filter");
    sleep_filter_a: assert property ($changed(rail_sleep)
        |-> quiet >= 11'h3e7) else $error("sleep moved before filter");
    vsel_cause_a: assert property ($changed(rail_vsel)
        |-> $past(hsel, 2) || $past(hsel, 3)
        || rail_sleep != $past(rail_sleep, 2))
        else $error("voltage code moved without cause");
    irq_quiet_a: assert property ((!hsel && $stable(power_good))[*4]
        |-> $stable(irq_out_n_oe)) else $error("interrupt moved alone");
    gout_cause_a: assert property (
        $changed({gen_out_a_o, gen_out_a_oe})
        |-> $past(hsel, 2) || $past(hsel, 3) || $past(hsel, 4)
        || power_good != $past(power_good, 3))
        else $error("general output moved without cause");
    rst_state_a: assert property ($fell(rst)
        |-> rail_enable == 8'h00 && !irq_out_n_oe)
        else $error("state not cleared by reset");
endmodule

// ---- sim/rcpl_regulators.sv ----
`timescale 1ns/10ps
// ==========
// regulators: power good trails enable by four cycles
module rcpl_regulators (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] rail_enable,
    input wire logic [7:0] fault,
    output logic [7:0] power_good
);
    logic [31:0] ramp;
    always_ff @(posedge clk) begin
        ramp <= rst ? 32'h0 : {ramp[23:0], rail_enable};
    end
    // a forced fault drops good at once, as a shorted rail would
    assign power_good = ramp[31:24] & ~fault;
endmodule

// ---- sim/rcpl_top_bench.sv ----
`timescale 1ns/10ps
module rcpl_top_bench;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, irq_o, irq_oe;
    logic [1:0] htrans;
    logic [2:0] hsize, go, goe;
    logic [31:0] haddr, hwdata, hrdata, rail_vsel, rd, vn, vs, c, s;
    logic [5:0] ctrl, hi;
    logic [7:0] power_good, rail_enable, rail_sleep, fault, f;
    logic [23:0] ga;
    int error_cnt, checks_done;

    rcpl_top i_rcpl_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rail_group_ctrl_a(ctrl[0]),
        .rail_group_ctrl_b(ctrl[1]), .rail_group_ctrl_c(ctrl[2]),
        .rail_group_ctrl_d(ctrl[3]), .rail_group_ctrl_e(ctrl[4]),
        .rail_group_ctrl_f(ctrl[5]), .power_good(power_good),
        .rail_enable(rail_enable), .rail_sleep(rail_sleep),
        .rail_vsel(rail_vsel), .gen_out_a_o(go[0]), .gen_out_a_oe(goe[0]),
        .gen_out_b_o(go[1]), .gen_out_b_oe(goe[1]), .gen_out_c_o(go[2]),
        .gen_out_c_oe(goe[2]), .irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe));
    rcpl_regulators i_rcpl_regulators (.clk(clk), .rst(rst),
        .rail_enable(rail_enable), .fault(fault), .power_good(power_good));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // ==========
    // helpers
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'h1 && n < 64);
        if (hreadyout !== 1'h1) begin
            error_cnt++;
            finish_test();
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, d);
        haddr <= a;
        hwrite <= wr;
        hsel <= 1'h1;
        htrans <= rcpl_pkg::HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    // pin edges are spaced past the filter time
    task automatic drive(input logic [5:0] v);
        ctrl <= v;
        settle(1010);
    endtask

    function automatic logic [7:0] en_exp(logic [5:0] h, logic [23:0] g);
        logic [7:0] e;
        for (int r = 0; r < 8; r++) begin
            e[r] = g[3*r+:3] != 3'h0 && h[g[3*r+:3] - 3'h1];
        end
        return e;
    endfunction

    function automatic logic [31:0] vsel_exp(logic [7:0] sl);
        logic [31:0] v;
        for (int r = 0; r < 8; r++) begin
            v[4*r+:4] = sl[r] ? vs[4*r+:4] : vn[4*r+:4];
        end
        return v;
    endfunction

    function automatic logic [1:0] pin_exp(logic [3:0] cf, logic lvl);
        logic v;
        v = cf[1] ? cf[2] : lvl;
        return cf[0] ? {1'h1, v} : {~v, 1'h0};
    endfunction

    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    // ==========
    // main sequence
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'h1, 68'h0};
        {hsize, ctrl, fault, error_cnt, checks_done} = {3'h2, 14'h0, 64'h0};
        void'($urandom(32'hd692));
        settle(5);
        rst <= 1'h0;
        for (int i = 0; i < 10; i++) begin
            bus(1'h0, 4 * i, 32'h0);
            check("reset value", rd, 32'h0);
        end
        vn = $urandom;
        vs = $urandom;
        bus(1'h1, rcpl_pkg::OFS_VSEL_NORM, vn);
        bus(1'h1, rcpl_pkg::OFS_VSEL_SLEEP, vs);
        bus(1'h1, 32'h24, $urandom);
        bus(1'h1, 32'h100, $urandom);
        bus(1'h0, 32'h100, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'h0, rcpl_pkg::OFS_VSEL_SLEEP, 32'h0);
        check("sleep code", rd, vs);
        check("normal code", rail_vsel, vn);
        drive(6'h24);
        bus(1'h1, rcpl_pkg::OFS_SLEEP_CFG, 32'h00f00f03);
        for (int k = 0; k < 2; k++) begin
            f = k ? 8'hf0 : 8'h0f;
            drive(k ? 6'h04 : 6'h20);
            check("asleep", rail_sleep, f);
            check("sleep code", rail_vsel, vsel_exp(f));
            check("no enable", rail_enable, 8'h00);
            drive(6'h24);
            check("awake", rail_sleep, 8'h00);
        end
        bus(1'h1, rcpl_pkg::OFS_SLEEP_CFG, 32'h0);
        drive(6'h00);
        for (int r = 0; r < 8; r++) ga[3*r+:3] = 3'h1 + 3'($urandom % 6);
        bus(1'h1, rcpl_pkg::OFS_GROUP_ASSIGN, {8'h0, ga});
        hi = 6'h00;
        for (int g = 0; g < 12; g++) begin
            hi[g % 6] = g < 6;
            drive(hi);
            check("enables", rail_enable, en_exp(hi, ga));
            if (g == 5) begin
                ctrl[0] <= 1'h0;
                settle(400);
                drive(hi);
                check("glitch", rail_enable, en_exp(hi, ga));
            end
        end
        bus(1'h1, rcpl_pkg::OFS_GROUP_ASSIGN, 32'h249249);
        drive(6'h01);
        for (int i = 0; i < 12; i++) begin
            c = $urandom & 32'h777;
            s = $urandom & 32'hffffff;
            f = 8'($urandom);
            fault <= f;
            bus(1'h1, rcpl_pkg::OFS_GOUT_CFG, c);
            bus(1'h1, rcpl_pkg::OFS_PG_SELECT, s);
            settle(8);
            for (int x = 0; x < 3; x++) begin
                check("gen out", {goe[x], go[x]},
                      pin_exp(c[4*x+:4], (~f & s[8*x+:8]) == s[8*x+:8]));
            end
        end
        fault <= 8'h00;
        settle(8);
        bus(1'h1, rcpl_pkg::OFS_IRQ_FLAG, 32'hff);
        bus(1'h1, rcpl_pkg::OFS_IRQ_MASK, 32'h01);
        settle(3);
        check("irq idle", irq_oe, 1'h0);
        fault <= 8'h03;
        settle(8);
        check("irq pending", irq_oe, 1'h1);
        bus(1'h1, rcpl_pkg::OFS_IRQ_MASK, 32'h04);
        settle(3);
        check("irq masked", irq_oe, 1'h0);
        bus(1'h1, rcpl_pkg::OFS_IRQ_MASK, 32'h02);
        bus(1'h1, rcpl_pkg::OFS_IRQ_FLAG, 32'h03);
        settle(3);
        check("irq cleared", irq_oe, 1'h0);
        bus(1'h0, rcpl_pkg::OFS_STATUS, 32'h0);
        check("status", rd, 32'h01fc00ff);
        finish_test();
    end
endmodule

bind rcpl_top rcpl_monitor i_rcpl_monitor (.clk(clk), .rst(rst), .hsel(hsel),
    .hreadyout(hreadyout), .hresp(hresp),
    .rail_group_ctrl_a(rail_group_ctrl_a),
    .rail_group_ctrl_b(rail_group_ctrl_b),
    .rail_group_ctrl_c(rail_group_ctrl_c),
    .rail_group_ctrl_d(rail_group_ctrl_d),
    .rail_group_ctrl_e(rail_group_ctrl_e),
    .rail_group_ctrl_f(rail_group_ctrl_f),
    .power_good(power_good), .rail_enable(rail_enable),
    .rail_sleep(rail_sleep), .rail_vsel(rail_vsel),
    .gen_out_a_o(gen_out_a_o), .gen_out_a_oe(gen_out_a_oe),
    .irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe));
